// *** bench/core_mode_stack_state_test.sv ***
// self-checking bench for the core mode, stack and status state block
`timescale 1ns/1ps
`include "core_mode_stack_state_cfg.svh"
module core_mode_stack_state_test;
  typedef struct packed {
    logic [3:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst, i_clk_en, i_vec_valid, i_reg_we, i_push, i_pop, i_pc_load;
  logic        i_instr_issue, i_flags_we, i_exc_enter, i_exc_return, i_exc_ret_tbit;
  logic        i_exc_ret_spsel, i_msr_we, i_mrs_re, i_ctrl_we;
  logic [31:0] i_vec_data, i_reg_wdata, i_push_data, i_pc_target, i_psr_wdata, i_ctrl_wdata;
  logic [3:0]  i_reg_waddr, i_reg_raddr, i_flags_in;
  logic [5:0]  i_exc_num, i_exc_ret_num;
  logic [2:0]  i_psr_sel;
  logic        o_vec_req, o_push_we, o_handler_mode, o_hardfault, o_lockup;
  logic [31:0] o_vec_addr, o_reg_rdata, o_push_addr, o_push_data, o_psr_rdata, o_ctrl_rdata;
  logic [31:0] o_main_stack_pointer, o_process_stack_pointer, o_program_counter;
  logic [31:0] o_combined_program_status;
  int          n_mismatch = 0;
  int          n_checks = 0;
  row_t        rows [6];
  logic [5:0]  codes [7];

  core_mode_stack_state u_core_mode_stack_state (
    .i_mclk, .i_sys_rst, .i_clk_en, .o_vec_req, .o_vec_addr, .i_vec_valid, .i_vec_data,
    .i_reg_we, .i_reg_waddr, .i_reg_wdata, .i_reg_raddr, .o_reg_rdata,
    .i_push, .i_pop, .i_push_data, .o_push_we, .o_push_addr, .o_push_data,
    .i_pc_load, .i_pc_target, .i_instr_issue, .i_flags_we, .i_flags_in,
    .i_exc_enter, .i_exc_num, .i_exc_return, .i_exc_ret_num, .i_exc_ret_tbit,
    .i_exc_ret_spsel, .i_msr_we, .i_mrs_re, .i_psr_sel, .i_psr_wdata, .o_psr_rdata,
    .i_ctrl_we, .i_ctrl_wdata, .o_ctrl_rdata, .o_handler_mode, .o_main_stack_pointer,
    .o_process_stack_pointer, .o_program_counter, .o_combined_program_status,
    .o_hardfault, .o_lockup
  );

  always #12.5 i_mclk = ~i_mclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(negedge i_mclk);
  endtask

  // the vector word is scrambled once taken so a late sample cannot pass by luck
  task automatic vec(input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    while (!(o_vec_req === 1'b1 && o_vec_addr === a) && k < 20) begin
      step();
      k++;
    end
    chk_word(o_vec_addr, a, "vector address");
    i_vec_valid = 1'b1;
    i_vec_data = d;
    step();
    i_vec_valid = 1'b0;
    i_vec_data = ~d;
    step();
  endtask

  task automatic boot();
    vec(`MSS_MSP_VECTOR_ADDR, 32'h2000_1000);
    vec(`MSS_PC_VECTOR_ADDR, 32'h0000_0101);
    step();
    chk_bit(o_vec_req, 1'b0, "fetch done");
    chk_word(o_main_stack_pointer, 32'h2000_1000, "main ptr boot");
    chk_word(o_program_counter, 32'h0000_0100, "pc boot");
    chk_word(o_combined_program_status & 32'h0FFF_FFFF, 32'h0100_0000, "status boot");
    chk_bit(o_handler_mode, 1'b0, "thread after boot");
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    i_reg_we = 1'b1;
    i_reg_waddr = a;
    i_reg_wdata = d;
    step();
    i_reg_we = 1'b0;
  endtask

  task automatic push(input logic [31:0] d, input logic [31:0] addr);
    i_push = 1'b1;
    i_push_data = d;
    step();
    i_push = 1'b0;
    chk_bit(o_push_we, 1'b1, "push strobe");
    chk_word(o_push_addr, addr, "push address");
    chk_word(o_push_data, d, "push data");
  endtask

  task automatic psr_read(input logic [2:0] sel, input logic [31:0] exp);
    i_mrs_re = 1'b1;
    i_psr_sel = sel;
    step();
    i_mrs_re = 1'b0;
    chk_word(o_psr_rdata, exp, "status read");
    step();
  endtask

  task automatic msr(input logic [2:0] sel, input logic [31:0] d);
    i_msr_we = 1'b1;
    i_psr_sel = sel;
    i_psr_wdata = d;
    step();
    i_msr_we = 1'b0;
    step();
  endtask

  task automatic exc(input logic enter, input logic [5:0] num, input logic spsel);
    i_exc_enter = enter;
    i_exc_return = ~enter;
    i_exc_num = num;
    i_exc_ret_num = num;
    i_exc_ret_spsel = spsel;
    step();
    i_exc_enter = 1'b0;
    i_exc_return = 1'b0;
    // an idle edge between calls, so a strobe is never lowered and raised in one step
    step();
  endtask

  initial begin
    {i_clk_en, i_exc_ret_tbit} = 2'b11;
    {i_vec_valid, i_reg_we, i_push, i_pop, i_pc_load, i_instr_issue} = '0;
    {i_flags_we, i_exc_enter, i_exc_return, i_exc_ret_spsel, i_msr_we} = '0;
    {i_mrs_re, i_ctrl_we, i_reg_waddr, i_reg_raddr, i_flags_in, i_psr_sel} = '0;
    {i_vec_data, i_reg_wdata, i_push_data, i_pc_target, i_psr_wdata} = '0;
    {i_ctrl_wdata, i_exc_num, i_exc_ret_num} = '0;
    rows = '{'{4'h0, 32'h1234_5678, 32'h1234_5678}, '{4'h7, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
             '{4'hC, 32'hFFFF_0001, 32'hFFFF_0001}, '{4'hE, 32'h0000_0F01, 32'h0000_0F01},
             '{`MSS_REG_SP, 32'h2000_0800, 32'h2000_0800},
             '{`MSS_REG_PC, 32'h0000_0301, 32'h0000_0300}};
    codes = '{`MSS_EXC_NMI, `MSS_EXC_HARDFAULT, `MSS_EXC_SVCALL, `MSS_EXC_PENDSV,
              `MSS_EXC_SYSTICK, `MSS_EXC_IRQ_FIRST, `MSS_EXC_IRQ_LAST};
    i_sys_rst = 1'b1;
    step(2);
    chk_bit(o_vec_req, 1'b1, "fetch in reset");
    chk_bit(o_handler_mode, 1'b0, "thread in reset");
    i_sys_rst = 1'b0;
    boot();
    foreach (rows[i]) begin
      reg_write(rows[i].idx, rows[i].wd);
      i_reg_raddr = rows[i].idx;
      step();
      chk_word(o_reg_rdata, rows[i].exp, "register readback");
    end
    chk_word(o_main_stack_pointer, 32'h2000_0800, "sp alias is main");
    push(32'hCAFE_0001, 32'h2000_07FC);
    chk_word(o_main_stack_pointer, 32'h2000_07FC, "main ptr after push");
    i_pop = 1'b1;
    step();
    i_pop = 1'b0;
    chk_word(o_main_stack_pointer, 32'h2000_0800, "main ptr after pop");
    // a stalled clock enable must swallow the push entirely
    i_clk_en = 1'b0;
    i_push = 1'b1;
    step();
    i_push = 1'b0;
    i_clk_en = 1'b1;
    step();
    chk_word(o_main_stack_pointer, 32'h2000_0800, "frozen push");
    i_ctrl_we = 1'b1;
    i_ctrl_wdata = 32'h0000_0002;
    step();
    i_ctrl_we = 1'b0;
    step();
    chk_word(o_ctrl_rdata, 32'h0000_0002, "select process");
    reg_write(`MSS_REG_SP, 32'h3000_0400);
    chk_word(o_process_stack_pointer, 32'h3000_0400, "process ptr write");
    push(32'hCAFE_0002, 32'h3000_03FC);
    chk_word(o_main_stack_pointer, 32'h2000_0800, "main ptr untouched");
    msr(3'h7, 32'hF1FF_FFFF);
    chk_word(o_combined_program_status, 32'hF100_0000, "msr all");
    psr_read(3'h7, 32'hF000_0000);
    msr(3'h2, 32'h0000_0000);
    msr(3'h1, 32'h5000_0000);
    chk_word(o_combined_program_status, 32'h5100_0000, "msr flags only");
    exc(1'b1, `MSS_EXC_SVCALL, 1'b0);
    step();
    chk_bit(o_handler_mode, 1'b1, "handler on entry");
    chk_word(o_ctrl_rdata, 32'h0000_0000, "select reads zero");
    psr_read(3'h7, 32'h5000_000B);
    psr_read(3'h1, 32'h5000_0000);
    psr_read(3'h2, 32'h0000_000B);
    psr_read(3'h4, 32'h0000_0000);
    push(32'hCAFE_0003, 32'h2000_07FC);
    exc(1'b1, `MSS_EXC_SYSTICK, 1'b0);
    exc(1'b0, `MSS_EXC_SVCALL, 1'b1);
    chk_bit(o_handler_mode, 1'b1, "nested return");
    exc(1'b0, `MSS_EXC_THREAD, 1'b1);
    step();
    chk_bit(o_handler_mode, 1'b0, "thread after return");
    chk_word(o_ctrl_rdata, 32'h0000_0002, "select restored");
    foreach (codes[i]) begin
      exc(1'b1, codes[i], 1'b0);
      chk_word(o_combined_program_status & 32'h3F, {26'h0, codes[i]}, "code");
      exc(1'b0, `MSS_EXC_THREAD, 1'b0);
    end
    exc(1'b1, 6'h01, 1'b0);
    exc(1'b1, 6'h30, 1'b0);
    chk_bit(o_handler_mode, 1'b0, "reserved codes refused");
    i_flags_we = 1'b1;
    i_flags_in = 4'hA;
    step();
    i_flags_we = 1'b0;
    chk_word(o_combined_program_status, 32'hA100_0000, "flag update");
    i_pc_load = 1'b1;
    i_pc_target = 32'h0000_0200;
    step();
    i_pc_load = 1'b0;
    chk_word(o_program_counter, 32'h0000_0200, "branch");
    chk_bit(o_combined_program_status[`MSS_TBIT_POS], 1'b0, "state bit cleared");
    i_instr_issue = 1'b1;
    step();
    i_instr_issue = 1'b0;
    chk_bit(o_hardfault, 1'b1, "fault on clear state");
    chk_bit(o_lockup, 1'b0, "no lockup yet");
    step();
    chk_bit(o_hardfault, 1'b0, "fault is a pulse");
    // a second clear-state issue while servicing the fault must lock up
    i_instr_issue = 1'b1;
    step();
    i_instr_issue = 1'b0;
    chk_bit(o_lockup, 1'b1, "lockup on fault in fault");
    i_sys_rst = 1'b1;
    step();
    chk_bit(o_handler_mode, 1'b0, "thread in second reset");
    chk_bit(o_lockup, 1'b0, "lockup cleared by reset");
    i_sys_rst = 1'b0;
    boot();
    stop_test();
  end

  // the whole sequence needs about a hundred cycles
  initial begin
    #(3000 * 25);
    n_mismatch++;
    stop_test();
  end
endmodule

// *** rtl/core_mode_stack_state.sv ***
// core programmers-model state: modes, dual stack pointers, registers, status word
//
// Overview of operation
// - reset leaves the core in thread mode
// - handler for exceptions, thread after all finish
// - push decrements pointer then stores item
// - separate main and process stack pointers
// - handler mode always uses main pointer
// - thread mode: select bit picks pointer, resets 0
// - reset loads main pointer from address 0
// - reset loads program counter from address 4
// - execution state bit 24 from vector bit 0
// - thirteen 32-bit general registers, undefined reset
// - register 13 aliases selected stack pointer
// - register 14 holds return link information
// - register 15 holds current instruction address
// - status word has three disjoint fields
// - status moves name any field combination
// - software writes to exception number discarded
// - execution state reads zero, ignores writes
// - flags N Z C V at bits 31..28
// - exception number resets zero, read only
// - exception codes: thread, faults, irq 16..47
// - handler mode: select bit reads zero, no writes
// - execute with state bit clear faults or locks
`timescale 1ns/1ps
`include "core_mode_stack_state_cfg.svh"
module core_mode_stack_state #(
  parameter int NUM_GPR = `MSS_NUM_GPR
) (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // vector fetch port toward memory
  output logic             o_vec_req,
  output logic      [31:0] o_vec_addr,
  input  wire logic        i_vec_valid,
  input  wire logic [31:0] i_vec_data,
  // general register write and read
  input  wire logic        i_reg_we,
  input  wire logic [3:0]  i_reg_waddr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic [3:0]  i_reg_raddr,
  output logic      [31:0] o_reg_rdata,
  // stack push and pop
  input  wire logic        i_push,
  input  wire logic        i_pop,
  input  wire logic [31:0] i_push_data,
  output logic             o_push_we,
  output logic      [31:0] o_push_addr,
  output logic      [31:0] o_push_data,
  // program counter flow
  input  wire logic        i_pc_load,
  input  wire logic [31:0] i_pc_target,
  input  wire logic        i_instr_issue,
  // condition flag update from execution
  input  wire logic        i_flags_we,
  input  wire logic [3:0]  i_flags_in,
  // exception entry and return
  input  wire logic        i_exc_enter,
  input  wire logic [5:0]  i_exc_num,
  input  wire logic        i_exc_return,
  input  wire logic [5:0]  i_exc_ret_num,
  input  wire logic        i_exc_ret_tbit,
  input  wire logic        i_exc_ret_spsel,
  // status move instructions
  input  wire logic        i_msr_we,
  input  wire logic        i_mrs_re,
  input  wire logic [2:0]  i_psr_sel,
  input  wire logic [31:0] i_psr_wdata,
  output logic      [31:0] o_psr_rdata,
  input  wire logic        i_ctrl_we,
  input  wire logic [31:0] i_ctrl_wdata,
  output logic      [31:0] o_ctrl_rdata,
  // state outputs
  output logic             o_handler_mode,
  output logic      [31:0] o_main_stack_pointer,
  output logic      [31:0] o_process_stack_pointer,
  output logic      [31:0] o_program_counter,
  output logic      [31:0] o_combined_program_status,
  output logic             o_hardfault,
  output logic             o_lockup
);
  core_mode_stack_state_pkg::boot_state_t boot_reg, boot_next;
  core_mode_stack_state_pkg::proc_mode_t  mode_reg;

  logic [31:0] gpr_reg [NUM_GPR];
  logic [31:0] main_stack_pointer_reg;
  logic [31:0] process_stack_pointer_reg;
  logic [31:0] return_link_register_reg;
  logic [31:0] program_counter_reg;
  logic [3:0]  flags_reg;
  logic [5:0]  exc_num_reg;
  logic        tbit_reg;
  logic        spsel_reg;
  logic        vec_req_reg;
  logic [31:0] vec_addr_reg;
  logic [31:0] reg_rdata_reg;
  logic [31:0] psr_rdata_reg;
  logic [31:0] ctrl_rdata_reg;
  logic        push_we_reg;
  logic [31:0] push_addr_reg;
  logic [31:0] push_data_reg;
  logic        hardfault_reg;
  logic        lockup_reg;

  wire         running;
  wire         in_handler;
  wire         use_psp;
  wire [31:0]  stack_pointer_alias;
  wire [31:0]  sp_dec;
  wire [31:0]  sp_inc;
  wire [31:0]  sp_next;
  wire         sp_write;
  wire [31:0]  sp_wval;
  wire         msr_flags;
  wire [3:0]   flags_next;
  wire [31:0]  psr_view;
  wire [31:0]  psr_full;
  wire         tbit_fault;
  wire         exec_ok;
  wire         exc_legal;

  assign running    = boot_reg == core_mode_stack_state_pkg::ST_RUN;
  assign in_handler = mode_reg == core_mode_stack_state_pkg::MODE_HANDLER;
  assign use_psp    = !in_handler && spsel_reg;
  assign stack_pointer_alias = use_psp ? process_stack_pointer_reg
                                       : main_stack_pointer_reg;
  // full descending: the decremented pointer is both new top and store address
  assign sp_dec   = stack_pointer_alias - 32'h0000_0004;
  assign sp_inc   = stack_pointer_alias + 32'h0000_0004;
  assign sp_write = running && i_reg_we && i_reg_waddr == `MSS_REG_SP;
  assign sp_wval  = {i_reg_wdata[31:2], 2'b00};
  assign sp_next  = sp_write ? sp_wval : (i_push ? sp_dec : sp_inc);

  // codes 1, 4-10, 12, 13 and 48-63 are reserved and refused on entry
  assign exc_legal = (i_exc_num == `MSS_EXC_NMI) || (i_exc_num == `MSS_EXC_HARDFAULT)
                  || (i_exc_num == `MSS_EXC_SVCALL) || (i_exc_num == `MSS_EXC_PENDSV)
                  || (i_exc_num == `MSS_EXC_SYSTICK)
                  || (i_exc_num >= `MSS_EXC_IRQ_FIRST && i_exc_num <= `MSS_EXC_IRQ_LAST);

  assign msr_flags  = running && i_msr_we && (i_psr_sel & `MSS_SEL_FLAGS) != 3'h0;
  assign flags_next = msr_flags ? i_psr_wdata[`MSS_FLAGS_MSB:`MSS_FLAGS_LSB]
                                : i_flags_in;

  // the stacked view keeps all three fields, software views do not
  assign psr_full = {flags_reg, 3'b000, tbit_reg, 18'h00000, exc_num_reg};
  assign tbit_fault = running && i_instr_issue && !tbit_reg;
  assign exec_ok    = running && !tbit_fault;

  status_view_mux u_view (
    .i_sel     (i_psr_sel),
    .i_flags   (flags_reg),
    .i_exc_num (exc_num_reg),
    .o_word    (psr_view)
  );

  // reset fetch sequence: stack word first, then the reset vector
  always_comb begin
    boot_next = boot_reg;
    case (boot_reg)
      core_mode_stack_state_pkg::ST_FETCH_SP:
        if (i_vec_valid) boot_next = core_mode_stack_state_pkg::ST_FETCH_PC;
      core_mode_stack_state_pkg::ST_FETCH_PC:
        if (i_vec_valid) boot_next = core_mode_stack_state_pkg::ST_RUN;
      core_mode_stack_state_pkg::ST_RUN:
        if (tbit_fault && in_handler && exc_num_reg == `MSS_EXC_HARDFAULT) begin
          boot_next = core_mode_stack_state_pkg::ST_LOCKUP;
        end
      core_mode_stack_state_pkg::ST_LOCKUP:
        boot_next = core_mode_stack_state_pkg::ST_LOCKUP;
      default:
        boot_next = core_mode_stack_state_pkg::ST_FETCH_SP;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      boot_reg     <= core_mode_stack_state_pkg::ST_FETCH_SP;
      vec_req_reg  <= 1'b1;
      vec_addr_reg <= `MSS_MSP_VECTOR_ADDR;
    end else if (i_clk_en) begin
      boot_reg     <= boot_next;
      vec_req_reg  <= boot_next != core_mode_stack_state_pkg::ST_RUN
                   && boot_next != core_mode_stack_state_pkg::ST_LOCKUP;
      vec_addr_reg <= boot_next == core_mode_stack_state_pkg::ST_FETCH_SP
                    ? `MSS_MSP_VECTOR_ADDR : `MSS_PC_VECTOR_ADDR;
    end
  end

  // mode follows exception entry and the final exception return
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mode_reg    <= core_mode_stack_state_pkg::MODE_THREAD;
      exc_num_reg <= `MSS_EXC_RESET;
    end else if (i_clk_en && running) begin
      if (i_exc_enter && exc_legal) begin
        mode_reg    <= core_mode_stack_state_pkg::MODE_HANDLER;
        exc_num_reg <= i_exc_num;
      end else if (tbit_fault) begin
        mode_reg    <= core_mode_stack_state_pkg::MODE_HANDLER;
        exc_num_reg <= `MSS_EXC_HARDFAULT;
      end else if (i_exc_return) begin
        exc_num_reg <= i_exc_ret_num;
        mode_reg    <= i_exc_ret_num == `MSS_EXC_THREAD
                     ? core_mode_stack_state_pkg::MODE_THREAD
                     : core_mode_stack_state_pkg::MODE_HANDLER;
      end
    end
  end

  // control select bit; ignored from software in handler mode
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      spsel_reg <= `MSS_CTRL_RESET;
    end else if (i_clk_en && running) begin
      if (i_exc_enter && exc_legal) begin
        spsel_reg <= 1'b0;
      end else if (i_exc_return) begin
        spsel_reg <= i_exc_ret_num == `MSS_EXC_THREAD ? i_exc_ret_spsel : 1'b0;
      end else if (i_ctrl_we && !in_handler) begin
        spsel_reg <= i_ctrl_wdata[`MSS_CTRL_SPSEL_BIT];
      end
    end
  end

  // two independent pointer copies, only the selected one moves
  always_ff @(posedge i_mclk) begin
    if (i_clk_en) begin
      if (boot_reg == core_mode_stack_state_pkg::ST_FETCH_SP && i_vec_valid) begin
        main_stack_pointer_reg <= {i_vec_data[31:2], 2'b00};
      end else if (running && (sp_write || i_push || i_pop) && !use_psp) begin
        main_stack_pointer_reg <= sp_next;
      end
      if (running && (sp_write || i_push || i_pop) && use_psp) begin
        process_stack_pointer_reg <= sp_next;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      push_we_reg <= 1'b0;
    end else if (i_clk_en) begin
      push_we_reg <= running && i_push && !sp_write;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_clk_en) begin
      push_addr_reg <= sp_dec;
      push_data_reg <= i_push_data;
    end
  end

  // program counter and execution state bit
  always_ff @(posedge i_mclk) begin
    if (i_clk_en) begin
      if (boot_reg == core_mode_stack_state_pkg::ST_FETCH_PC && i_vec_valid) begin
        program_counter_reg <= {i_vec_data[31:1], 1'b0};
        tbit_reg            <= i_vec_data[0];
      end else if (running && i_exc_return) begin
        tbit_reg            <= i_exc_ret_tbit;
      end else if (running && i_pc_load) begin
        program_counter_reg <= {i_pc_target[31:1], 1'b0};
        tbit_reg            <= i_pc_target[0];
      end else if (running && i_reg_we && i_reg_waddr == `MSS_REG_PC) begin
        program_counter_reg <= {i_reg_wdata[31:1], 1'b0};
      end
    end
  end

  // general registers and link: no reset, contents undefined
  always_ff @(posedge i_mclk) begin
    if (i_clk_en && running && i_reg_we) begin
      if (i_reg_waddr < 4'(NUM_GPR)) begin
        gpr_reg[i_reg_waddr] <= i_reg_wdata;
      end
      if (i_reg_waddr == `MSS_REG_LR) begin
        return_link_register_reg <= i_reg_wdata;
      end
    end
  end

  // flags: software path through the status move, else execution
  always_ff @(posedge i_mclk) begin
    if (i_clk_en && (msr_flags || (running && i_flags_we))) begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      reg_rdata_reg  <= 32'h0000_0000;
      psr_rdata_reg  <= 32'h0000_0000;
      ctrl_rdata_reg <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (i_reg_raddr == `MSS_REG_SP) begin
        reg_rdata_reg <= stack_pointer_alias;
      end else if (i_reg_raddr == `MSS_REG_LR) begin
        reg_rdata_reg <= return_link_register_reg;
      end else if (i_reg_raddr == `MSS_REG_PC) begin
        reg_rdata_reg <= program_counter_reg;
      end else begin
        reg_rdata_reg <= gpr_reg[i_reg_raddr];
      end
      if (i_mrs_re) begin
        psr_rdata_reg <= psr_view;
      end
      ctrl_rdata_reg <= {30'h0, use_psp, 1'b0};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      hardfault_reg <= 1'b0;
      lockup_reg    <= 1'b0;
    end else if (i_clk_en) begin
      hardfault_reg <= tbit_fault;
      lockup_reg    <= boot_next == core_mode_stack_state_pkg::ST_LOCKUP;
    end
  end

  assign o_vec_req                 = vec_req_reg;
  assign o_vec_addr                = vec_addr_reg;
  assign o_reg_rdata               = reg_rdata_reg;
  assign o_psr_rdata               = psr_rdata_reg;
  assign o_ctrl_rdata              = ctrl_rdata_reg;
  assign o_push_we                 = push_we_reg;
  assign o_push_addr               = push_addr_reg;
  assign o_push_data               = push_data_reg;
  assign o_handler_mode            = mode_reg;
  assign o_main_stack_pointer      = main_stack_pointer_reg;
  assign o_process_stack_pointer   = process_stack_pointer_reg;
  assign o_program_counter         = program_counter_reg;
  assign o_combined_program_status = psr_full;
  assign o_hardfault               = hardfault_reg;
  assign o_lockup                  = lockup_reg;

  property p_reset_thread;
    @(posedge i_mclk) $fell(i_sys_rst) |-> !o_handler_mode;
  endproperty
  a_reset_thread: assert property (p_reset_thread) else $error("not thread after reset");

  property p_enter_handler;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && running && i_exc_enter && exc_legal) |=> o_handler_mode && exc_num_reg == $past(i_exc_num);
  endproperty
  a_enter_handler: assert property (p_enter_handler) else $error("exception entry missed");

  property p_push_desc;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && running && i_push && !sp_write) |=> o_push_we && o_push_addr == $past(sp_dec);
  endproperty
  a_push_desc: assert property (p_push_desc) else $error("push address not decremented");

  property p_psp_hold;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && running && !use_psp) |=> $stable(process_stack_pointer_reg);
  endproperty
  a_psp_hold: assert property (p_psp_hold) else $error("process pointer moved");

  property p_handler_msp;
    @(posedge i_mclk) disable iff (i_sys_rst) in_handler |-> stack_pointer_alias == main_stack_pointer_reg;
  endproperty
  a_handler_msp: assert property (p_handler_msp) else $error("handler not on main stack");

  property p_msp_boot;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && boot_reg == core_mode_stack_state_pkg::ST_FETCH_SP && i_vec_valid)
      |=> main_stack_pointer_reg == {$past(i_vec_data[31:2]), 2'b00};
  endproperty
  a_msp_boot: assert property (p_msp_boot) else $error("main pointer not loaded");

  property p_tbit_boot;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && boot_reg == core_mode_stack_state_pkg::ST_FETCH_PC && i_vec_valid)
      |=> tbit_reg == $past(i_vec_data[0]) && running;
  endproperty
  a_tbit_boot: assert property (p_tbit_boot) else $error("state bit not loaded");

  property p_exec_zero;
    @(posedge i_mclk) disable iff (i_sys_rst) psr_rdata_reg[`MSS_TBIT_POS] == 1'b0;
  endproperty
  a_exec_zero: assert property (p_exec_zero) else $error("execution state visible");

  property p_ctrl_handler;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && in_handler) |=> o_ctrl_rdata[`MSS_CTRL_SPSEL_BIT] == 1'b0;
  endproperty
  a_ctrl_handler: assert property (p_ctrl_handler) else $error("select bit visible in handler");

  property p_tfault;
    @(posedge i_mclk) disable iff (i_sys_rst) (i_clk_en && tbit_fault) |=> o_hardfault;
  endproperty
  a_tfault: assert property (p_tfault) else $error("state bit fault not raised");
endmodule

// *** rtl/core_mode_stack_state_cfg.svh ***
// constants for the core mode, stack and status register state
`ifndef CORE_MODE_STACK_STATE_CFG_SVH
`define CORE_MODE_STACK_STATE_CFG_SVH
`define MSS_MSP_VECTOR_ADDR   32'h0000_0000
`define MSS_PC_VECTOR_ADDR    32'h0000_0004
`define MSS_NUM_GPR           13
`define MSS_REG_SP            4'hD
`define MSS_REG_LR            4'hE
`define MSS_REG_PC            4'hF
`define MSS_FLAG_N_BIT        31
`define MSS_FLAG_Z_BIT        30
`define MSS_FLAG_C_BIT        29
`define MSS_FLAG_V_BIT        28
`define MSS_FLAGS_MSB         31
`define MSS_FLAGS_LSB         28
`define MSS_EXC_MSB           5
`define MSS_EXC_LSB           0
`define MSS_TBIT_POS          24
`define MSS_CTRL_SPSEL_BIT    1
`define MSS_EXC_THREAD        6'h00
`define MSS_EXC_NMI           6'h02
`define MSS_EXC_HARDFAULT     6'h03
`define MSS_EXC_SVCALL        6'h0B
`define MSS_EXC_PENDSV        6'h0E
`define MSS_EXC_SYSTICK       6'h0F
`define MSS_EXC_IRQ_FIRST     6'h10
`define MSS_EXC_IRQ_LAST      6'h2F
`define MSS_EXC_RESET         6'h00
`define MSS_CTRL_RESET        1'h0
`define MSS_SEL_FLAGS         3'h1
`define MSS_SEL_EXC           3'h2
`define MSS_SEL_EXEC          3'h4
`endif

// *** rtl/core_mode_stack_state_pkg.sv ***
// types for the core mode, stack and status register state
package core_mode_stack_state_pkg;
  typedef enum logic [1:0] {
    ST_FETCH_SP = 2'b00,
    ST_FETCH_PC = 2'b01,
    ST_RUN      = 2'b10,
    ST_LOCKUP   = 2'b11
  } boot_state_t;
  typedef enum logic {
    MODE_THREAD  = 1'b0,
    MODE_HANDLER = 1'b1
  } proc_mode_t;
endpackage

// *** rtl/status_view_mux.sv ***
// status word assembly for one software view of the combined status
`timescale 1ns/1ps
`include "core_mode_stack_state_cfg.svh"
module status_view_mux (
  input  wire logic [2:0]  i_sel,
  input  wire logic [3:0]  i_flags,
  input  wire logic [5:0]  i_exc_num,
  output logic      [31:0] o_word
);
  wire [31:0] flags_part;
  wire [31:0] exc_part;
  // reserved bits stay zero; the execution state never reaches software
  assign flags_part = (i_sel & `MSS_SEL_FLAGS) != 3'h0 ? {i_flags, 28'h0000000} : 32'h0;
  assign exc_part   = (i_sel & `MSS_SEL_EXC) != 3'h0 ? {26'h0, i_exc_num} : 32'h0;
  assign o_word     = flags_part | exc_part;
endmodule
